/* core/qrf_pkg.sv */
/*
  constants for the queued receive buffer: register map, field layout,
  queue shape and protocol-state codes.
  assumes a 32-bit register port with byte addresses, one word per register.
*/
package qrf_pkg;

  // queue shape
  localparam int unsigned QRF_DEPTH     = 4;
  localparam int unsigned QRF_PTR_W     = 2;
  localparam int unsigned QRF_CNT_W     = 3;
  localparam int unsigned QRF_WIDTH     = 8;   // two-byte words per entry
  localparam int unsigned QRF_WIDX_W    = 3;
  localparam int unsigned QRF_MEM_AW    = 5;

  // header field widths
  localparam int unsigned QRF_ID_W      = 11;
  localparam int unsigned QRF_CYC_W     = 6;
  localparam int unsigned QRF_LEN_W     = 7;
  localparam int unsigned QRF_CRC_W     = 11;

  // protocol state codes seen on poc_state
  localparam logic [2:0] QRF_ST_CONFIG  = 3'h1;
  localparam logic [2:0] QRF_ST_ACTIVE  = 3'h2;
  localparam logic [2:0] QRF_ST_PASSIVE = 3'h3;
  localparam logic [2:0] QRF_ST_HALT    = 3'h4;
  localparam logic [2:0] QRF_ST_READY   = 3'h5;

  // register byte offsets
  localparam logic [7:0] QRF_A_STATUS   = 8'h00;
  localparam logic [7:0] QRF_A_POP      = 8'h04;
  localparam logic [7:0] QRF_A_ESTAT    = 8'h08;
  localparam logic [7:0] QRF_A_HDR0     = 8'h0C;
  localparam logic [7:0] QRF_A_HDR1     = 8'h10;
  localparam logic [7:0] QRF_A_CRIT_CH  = 8'h20;
  localparam logic [7:0] QRF_A_CRIT_ID  = 8'h24;
  localparam logic [7:0] QRF_A_APPLY    = 8'h28;
  localparam logic [7:0] QRF_A_RUNWR    = 8'h2C;
  localparam logic [7:0] QRF_A_DATA     = 8'h40; // words at +4*i

  // field positions
  localparam int unsigned QRF_B_LOST    = 8;   // status: lost flag
  localparam int unsigned QRF_B_EMPTY   = 4;   // status: empty
  localparam int unsigned QRF_B_FULL    = 5;   // status: full
  localparam int unsigned QRF_B_IDMAX   = 16;  // crit_id: max at [26:16]

  // reset values of criteria
  localparam logic [1:0]          QRF_RST_CHAN  = 2'h3;
  localparam logic                QRF_RST_NULL  = 1'b0;
  localparam logic [QRF_ID_W-1:0] QRF_RST_IDMIN = 11'h001;
  localparam logic [QRF_ID_W-1:0] QRF_RST_IDMAX = 11'h7FF;

endpackage : qrf_pkg

/* core/qrf_queue.sv */
/*
  queued receive buffer: admits frames from the protocol engine into a
  first-in-first-out queue and lets the host read and remove the oldest.
  assumes the protocol engine runs on ref_clk, streams payload words before
  pulsing pe_slot_done, and that host strobes are single-cycle.
*/
module qrf_queue
  import qrf_pkg::*;
(
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  // register port
  input  wire logic [7:0]           reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic      [31:0]          reg_rdata,
  // protocol state
  input  wire logic [2:0]           poc_state,
  input  wire logic                 first_boot_slot,
  input  wire logic                 nq_search_done,
  // protocol engine slot result
  input  wire logic                 pe_word_valid,
  input  wire logic [15:0]          pe_word_data,
  input  wire logic                 pe_slot_done,
  input  wire logic                 nq_match,
  input  wire logic                 rx_channel_source,
  input  wire logic                 slot_frame_valid,
  input  wire logic                 slot_syntax_fault,
  input  wire logic                 slot_content_fault,
  input  wire logic                 slot_boundary_fault,
  input  wire logic                 slot_payload_present,
  input  wire logic                 hdr_reserved_bit,
  input  wire logic [QRF_ID_W-1:0]  hdr_frame_ident,
  input  wire logic [QRF_CYC_W-1:0] hdr_cycle_number,
  input  wire logic [QRF_LEN_W-1:0] hdr_payload_words,
  input  wire logic [QRF_CRC_W-1:0] hdr_checksum,
  input  wire logic                 hdr_preamble_flag,
  input  wire logic                 hdr_sync_flag,
  input  wire logic                 hdr_startup_flag,
  // status pins
  output logic                      queue_not_empty,
  output logic                      queue_lost
);

  // per-entry snapshot; payload in one flat array
  logic [3:0]           e_flags   [QRF_DEPTH];
  logic                 e_chan    [QRF_DEPTH];
  logic                 e_rsv     [QRF_DEPTH];
  logic [QRF_ID_W-1:0]  e_id      [QRF_DEPTH];
  logic [QRF_CYC_W-1:0] e_cyc     [QRF_DEPTH];
  logic [QRF_LEN_W-1:0] e_len     [QRF_DEPTH];
  logic [QRF_CRC_W-1:0] e_crc     [QRF_DEPTH];
  logic [2:0]           e_ind     [QRF_DEPTH];
  logic [15:0]          e_data    [QRF_DEPTH*QRF_WIDTH];

  logic [QRF_PTR_W-1:0] wr_ptr_q;
  logic [QRF_PTR_W-1:0] rd_ptr_q;
  logic [QRF_CNT_W-1:0] count_q;
  logic [QRF_WIDX_W:0]  widx_q;
  logic                 taint_q;
  logic                 lost_q;

  // criteria: shadow copy written by host, active copy used for admission
  logic [1:0]           sh_chan_q;
  logic                 sh_null_q;
  logic [QRF_ID_W-1:0]  sh_idmin_q;
  logic [QRF_ID_W-1:0]  sh_idmax_q;
  logic [1:0]           ac_chan_q;
  logic                 ac_null_q;
  logic [QRF_ID_W-1:0]  ac_idmin_q;
  logic [QRF_ID_W-1:0]  ac_idmax_q;
  logic                 runwr_en_q;

  logic                 full;
  logic                 empty;
  logic                 in_config;
  logic                 in_run;
  logic                 crit_wr_ok;
  logic                 wr_hit;
  logic                 pop;
  logic                 criteria_ok;
  logic                 candidate;
  logic                 admit;
  logic                 commit;
  logic                 drop;
  logic                 word_ok;
  logic [QRF_MEM_AW-1:0] waddr;
  logic [QRF_MEM_AW-1:0] raddr;
  logic [QRF_WIDX_W-1:0] ridx;
  logic [31:0]          rdata_d;

  assign full      = (count_q == QRF_CNT_W'(QRF_DEPTH));
  assign empty     = (count_q == '0);
  assign in_config = (poc_state == QRF_ST_CONFIG);
  assign in_run    = (poc_state == QRF_ST_ACTIVE) || (poc_state == QRF_ST_PASSIVE);

  // criteria writes only in config, or in run when enabled from config
  assign crit_wr_ok = in_config || (in_run && runwr_en_q);

  assign wr_hit = reg_wr && crit_wr_ok;
  // removal ignored on empty queue so pointers never pass each other
  assign pop    = reg_wr && (reg_addr == QRF_A_POP) && !empty;

  // frame validity, null frames, channel and identifier range, the last three from the active copy
  assign criteria_ok = slot_frame_valid
                    && (slot_payload_present || ac_null_q)
                    && ac_chan_q[rx_channel_source]
                    && (hdr_frame_ident != '0)
                    && (hdr_frame_ident >= ac_idmin_q)
                    && (hdr_frame_ident <= ac_idmax_q);

  // non-queued buffers win; skipped in first boot slot unless search finished
  assign candidate = in_run && !nq_match
                  && (!first_boot_slot || nq_search_done);

  // single queue: the fixed selection rule always picks this one
  assign admit  = pe_slot_done && candidate && criteria_ok;
  // a payload word dropped on a full queue makes the entry incoherent, so it is not kept
  assign commit = admit && !full && !taint_q;
  assign drop   = admit && (full || taint_q);

  assign word_ok = pe_word_valid && (widx_q < (QRF_WIDX_W+1)'(QRF_WIDTH));
  assign waddr   = {wr_ptr_q, widx_q[QRF_WIDX_W-1:0]};
  assign ridx    = reg_addr[QRF_WIDX_W+1:2];
  assign raddr   = {rd_ptr_q, ridx};

  // payload words land in the slot beyond the newest entry; invisible
  // to the host until the pointer moves, which makes the write indivisible
  always_ff @(posedge ref_clk) begin
    if (word_ok && !full) begin
      e_data[waddr] <= pe_word_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      widx_q  <= '0;
      taint_q <= 1'b0;
    end else if (pe_slot_done) begin
      widx_q  <= '0;
      taint_q <= 1'b0;
    end else if (word_ok) begin
      widx_q  <= widx_q + 1'b1;
      taint_q <= taint_q || full;
    end
  end

  // snapshot of slot status and header at commit
  generate
    for (genvar g = 0; g < QRF_DEPTH; g++) begin : g_entry
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          e_flags[g] <= '0;
          e_chan[g]  <= 1'b0;
          e_rsv[g]   <= 1'b0;
          e_id[g]    <= '0;
          e_cyc[g]   <= '0;
          e_len[g]   <= '0;
          e_crc[g]   <= '0;
          e_ind[g]   <= '0;
        end else if (commit && (wr_ptr_q == QRF_PTR_W'(g))) begin
          e_flags[g] <= {slot_payload_present, slot_boundary_fault,
                         slot_content_fault, slot_syntax_fault};
          e_chan[g]  <= rx_channel_source;
          e_rsv[g]   <= hdr_reserved_bit;
          e_id[g]    <= hdr_frame_ident;
          e_cyc[g]   <= hdr_cycle_number;
          e_len[g]   <= hdr_payload_words;
          e_crc[g]   <= hdr_checksum;
          e_ind[g]   <= {hdr_startup_flag, hdr_sync_flag, hdr_preamble_flag};
        end
      end
    end
  endgenerate

  // pointers and fill level; admission and removal may share a cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (commit) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      case ({commit, pop})
        2'b10:   count_q <= count_q + 1'b1;
        2'b01:   count_q <= count_q - 1'b1;
        default: count_q <= count_q;
      endcase
    end
  end

  // lost flag: hardware set wins over a host clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lost_q <= 1'b0;
    end else if (drop) begin
      lost_q <= 1'b1;
    end else if (reg_wr && (reg_addr == QRF_A_STATUS) && reg_wdata[QRF_B_LOST]) begin
      lost_q <= 1'b0;
    end
  end

  // runtime write enable may only change during configuration
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      runwr_en_q <= 1'b0;
    end else if (reg_wr && in_config && (reg_addr == QRF_A_RUNWR)) begin
      runwr_en_q <= reg_wdata[0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sh_chan_q  <= QRF_RST_CHAN;
      sh_null_q  <= QRF_RST_NULL;
      sh_idmin_q <= QRF_RST_IDMIN;
      sh_idmax_q <= QRF_RST_IDMAX;
    end else if (wr_hit && (reg_addr == QRF_A_CRIT_CH)) begin
      sh_chan_q  <= reg_wdata[1:0];
      sh_null_q  <= reg_wdata[2];
    end else if (wr_hit && (reg_addr == QRF_A_CRIT_ID)) begin
      sh_idmin_q <= reg_wdata[QRF_ID_W-1:0];
      sh_idmax_q <= reg_wdata[QRF_B_IDMAX +: QRF_ID_W];
    end
  end

  // the whole set moves to the active copy in one cycle on apply, so a
  // frame is checked against either the old or the new set, never a mix;
  // stored entries are untouched by the change
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ac_chan_q  <= QRF_RST_CHAN;
      ac_null_q  <= QRF_RST_NULL;
      ac_idmin_q <= QRF_RST_IDMIN;
      ac_idmax_q <= QRF_RST_IDMAX;
    end else if (wr_hit && (reg_addr == QRF_A_APPLY)) begin
      ac_chan_q  <= sh_chan_q;
      ac_null_q  <= sh_null_q;
      ac_idmin_q <= sh_idmin_q;
      ac_idmax_q <= sh_idmax_q;
    end
  end

  // reads have no side effect and do not depend on protocol state; an
  // empty queue reads zero at the entry registers, with the entry-valid bit low
  always_comb begin
    rdata_d = '0;
    if (reg_addr >= QRF_A_DATA) begin
      // words past the stored length read as zero, never as a stale earlier frame
      if (!empty && (reg_addr < QRF_A_DATA + 8'(4*QRF_WIDTH))
          && (QRF_LEN_W'(ridx) < e_len[rd_ptr_q])) begin
        rdata_d[15:0] = e_data[raddr];
      end
    end else begin
      case (reg_addr)
        QRF_A_STATUS: begin
          rdata_d[QRF_CNT_W-1:0] = count_q;
          rdata_d[QRF_B_EMPTY]   = empty;
          rdata_d[QRF_B_FULL]    = full;
          rdata_d[QRF_B_LOST]    = lost_q;
        end
        QRF_A_ESTAT: begin
          if (!empty) begin
            rdata_d[3:0] = e_flags[rd_ptr_q];
            rdata_d[4]   = e_chan[rd_ptr_q];
            rdata_d[31]  = 1'b1;
          end
        end
        QRF_A_HDR0: begin
          if (!empty) begin
            rdata_d[QRF_ID_W-1:0] = e_id[rd_ptr_q];
            rdata_d[21:16]        = e_cyc[rd_ptr_q];
            rdata_d[24]           = e_rsv[rd_ptr_q];
            rdata_d[27:25]        = e_ind[rd_ptr_q];
          end
        end
        QRF_A_HDR1: begin
          if (!empty) begin
            rdata_d[QRF_LEN_W-1:0] = e_len[rd_ptr_q];
            rdata_d[26:16]         = e_crc[rd_ptr_q];
          end
        end
        QRF_A_CRIT_CH: begin
          rdata_d[1:0] = sh_chan_q;
          rdata_d[2]   = sh_null_q;
          rdata_d[8:7] = ac_chan_q;
          rdata_d[9]   = ac_null_q;
        end
        QRF_A_CRIT_ID: begin
          rdata_d[QRF_ID_W-1:0]              = sh_idmin_q;
          rdata_d[QRF_B_IDMAX +: QRF_ID_W]   = sh_idmax_q;
        end
        QRF_A_RUNWR: rdata_d[0] = runwr_en_q;
        default:     rdata_d = '0;
      endcase
    end
  end

  // halt and ready change nothing on the read side
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end else begin
      reg_rdata <= '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      queue_not_empty <= 1'b0;
      queue_lost      <= 1'b0;
    end else begin
      queue_not_empty <= (count_q != '0) || commit;
      queue_lost      <= lost_q || drop;
    end
  end

endmodule : qrf_queue

/* verification/qrf_pe_model.sv */
/*
  protocol engine model: streams payload words, then pulses slot end with header.
  assumes send() is entered just after a rising edge of ref_clk.
*/
module qrf_pe_model
  import qrf_pkg::*;
(
  input  wire logic            ref_clk,
  output logic                 pe_word_valid,
  output logic [15:0]          pe_word_data,
  output logic                 pe_slot_done,
  output logic                 slot_frame_valid,
  output logic [QRF_ID_W-1:0]  hdr_frame_ident,
  output logic [QRF_LEN_W-1:0] hdr_payload_words,
  output logic                 rx_channel_source
);
  initial begin
    pe_word_valid = 1'b0;
    pe_word_data = 16'h0000;
    pe_slot_done = 1'b0;
    slot_frame_valid = 1'b0;
    hdr_frame_ident = '0;
    hdr_payload_words = '0;
    rx_channel_source = 1'b0;
  end

  // every word of the header length is sent, so truncation is up to the queue
  task automatic send(input logic [QRF_ID_W-1:0] id, input logic [QRF_LEN_W-1:0] len,
                      input logic ch, input logic vld);
    for (int k = 0; k < int'(len); k++) begin
      pe_word_valid <= 1'b1;
      pe_word_data  <= {id[7:0], 8'(k)} ^ 16'hA5A5;
      @(posedge ref_clk);
    end
    pe_word_valid     <= 1'b0;
    pe_slot_done      <= 1'b1;
    slot_frame_valid  <= vld;
    hdr_frame_ident   <= id;
    hdr_payload_words <= len;
    rx_channel_source <= ch;
    @(posedge ref_clk);
    pe_slot_done      <= 1'b0;
    // released lines must not keep showing the last frame
    hdr_frame_ident   <= ~id;
    hdr_payload_words <= ~len;
    pe_word_data      <= ~pe_word_data;
    // one quiet edge, so a following frame never reassigns a released line
    @(posedge ref_clk);
  endtask : send
endmodule : qrf_pe_model

/* verification/qrf_checker.sv */
/*
  port assertions for the queued receive buffer.
  assumes it is bound to qrf_queue and sees only its ports.
*/
module qrf_checker
  import qrf_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [2:0]  poc_state,
  input wire logic        first_boot_slot,
  input wire logic        nq_search_done,
  input wire logic        pe_word_valid,
  input wire logic        pe_slot_done,
  input wire logic        nq_match,
  input wire logic        slot_frame_valid,
  input wire logic        queue_not_empty,
  input wire logic        queue_lost
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic pop_wr, clr_wr, run_st;
  assign pop_wr = reg_wr && reg_addr == QRF_A_POP;
  assign clr_wr = reg_wr && reg_addr == QRF_A_STATUS && reg_wdata[QRF_B_LOST];
  assign run_st = poc_state == QRF_ST_ACTIVE || poc_state == QRF_ST_PASSIVE;

  property stay_empty(c);
    pe_slot_done && c && !queue_not_empty |=> !queue_not_empty;
  endproperty

  rdata_idle_a: assert property (
    !$past(reg_rd) |-> reg_rdata == 32'h0000_0000) else $error("read data outside slot");
  idle_no_admit_a: assert property (stay_empty(!run_st))
    else $error("frame admitted outside run states");
  nq_priority_a: assert property (stay_empty(nq_match))
    else $error("frame admitted despite buffer match");
  boot_skip_a: assert property (stay_empty(first_boot_slot && !nq_search_done))
    else $error("boot slot admitted without full search");
  invalid_drop_a: assert property (stay_empty(!slot_frame_valid))
    else $error("invalid frame admitted");
  admit_source_a: assert property (
    $rose(queue_not_empty) |-> $past(pe_slot_done)) else $error("entry without slot end");
  pop_only_a: assert property (
    $fell(queue_not_empty) |-> $past(pop_wr) || $past(pop_wr, 2))
    else $error("entry lost without removal");
  lost_cause_a: assert property (
    $rose(queue_lost) |-> $past(pe_slot_done) || $past(pe_word_valid))
    else $error("lost flag without incoming data");
  lost_hold_a: assert property (
    $fell(queue_lost) |-> $past(clr_wr) || $past(clr_wr, 2))
    else $error("lost flag cleared without host write");
  empty_read_a: assert property (
    reg_rd && reg_addr == QRF_A_ESTAT && !queue_not_empty && !$past(pe_slot_done)
    |=> reg_rdata == 32'h0000_0000) else $error("empty queue shows an entry");

  cover property (pe_slot_done && pop_wr);
  cover property ($rose(queue_lost));
  cover property ($fell(queue_not_empty));
endmodule : qrf_checker

/* verification/tb_top.sv */
/*
  self-checking bench for qrf_queue: random frames with corner cases, host
  reads and removals. assumes qrf_pe_model and qrf_checker compiled before.
*/
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  $display("unexpected %s: expected %h seen %h", nm, e, g); n_errors++; end end
module tb_top
  import qrf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, nq_match = 1'b0;
  logic first_boot_slot = 1'b0, nq_search_done = 1'b1, slot_payload_present = 1'b1;
  logic slot_syntax_fault = 1'b0, slot_content_fault = 1'b0, slot_boundary_fault = 1'b0;
  logic hdr_reserved_bit = 1'b0, hdr_preamble_flag = 1'b0, hdr_sync_flag = 1'b0;
  logic hdr_startup_flag = 1'b0, queue_not_empty, queue_lost;
  logic pe_word_valid, pe_slot_done, rx_channel_source, slot_frame_valid;
  logic [7:0]           reg_addr = 8'h00;
  logic [31:0]          reg_wdata = 32'h0000_0000, reg_rdata;
  logic [2:0]           poc_state = QRF_ST_CONFIG;
  logic [15:0]          pe_word_data;
  logic [QRF_ID_W-1:0]  hdr_frame_ident;
  logic [QRF_LEN_W-1:0] hdr_payload_words;
  logic [QRF_CYC_W-1:0] hdr_cycle_number = '0;
  logic [QRF_CRC_W-1:0] hdr_checksum = '0;
  logic [31:0]          q_st[$], q_h0[$], q_h1[$];
  logic [1:0]           ch_pick = 2'b11;
  int                   n_errors = 0, samples_checked = 0, cycles = 0;
  integer               seed = 32'h2e22;

  qrf_queue DUT (.*);
  qrf_pe_model src (.*);

  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up

  // each access lets one edge pass after its strobe, so the next call never
  // raises a strobe in the time step that lowered it
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 `CHK(nm, e, reg_rdata)
    @(posedge ref_clk);
  endtask : rd

  task automatic pins(input logic ne, input logic lo);
    #1 `CHK("queue_not_empty", ne, queue_not_empty)
    `CHK("queue_lost", lo, queue_lost)
    @(posedge ref_clk);
  endtask : pins

  function automatic logic [31:0] exp_word(input logic [10:0] id, input int k);
    return {16'h0, id[7:0], 8'(k)} ^ 32'h0000_A5A5;
  endfunction : exp_word

  task automatic frame(input logic [10:0] id, input logic [6:0] len, input logic vld,
                       input logic adm);
    logic ch;
    logic [23:0] r;
    ch = 1'($random(seed));
    r = 24'($random(seed));
    if (ch_pick != 2'b11) ch = ch_pick[0];
    {slot_syntax_fault, slot_content_fault, slot_boundary_fault, hdr_reserved_bit,
     hdr_preamble_flag, hdr_sync_flag, hdr_startup_flag, hdr_cycle_number, hdr_checksum} <= r;
    if (adm) begin
      q_st.push_back({1'b1, 26'h0, ch, slot_payload_present, r[21], r[22], r[23]});
      q_h0.push_back({4'h0, r[17], r[18], r[19], r[20], 2'h0, r[16:11], 5'h0, id});
      q_h1.push_back({5'h0, r[10:0], 9'h0, len});
    end
    src.send(id, len, ch, vld);
  endtask : frame

  task automatic drain();
    logic [31:0] h0, h1;
    h0 = q_h0[0];
    h1 = q_h1[0];
    rd(QRF_A_ESTAT, q_st[0], "entry status");
    rd(QRF_A_ESTAT, q_st[0], "entry status again");
    rd(QRF_A_HDR0, h0, "header word 0");
    rd(QRF_A_HDR1, h1, "header word 1");
    for (int k = 0; k < 8 && k < int'(h1[6:0]); k++)
      rd(8'(QRF_A_DATA + 4 * k), exp_word(h0[10:0], k), "payload");
    if (int'(h1[6:0]) < 8)
      rd(8'(QRF_A_DATA + 4 * int'(h1[6:0])), 32'h0000_0000, "payload past length");
    wr(QRF_A_POP, 32'h0000_0000);
    void'(q_st.pop_front());
    void'(q_h0.pop_front());
    void'(q_h1.pop_front());
  endtask : drain

  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rd(QRF_A_STATUS, 32'h0000_0010, "status after reset");
    rd(QRF_A_ESTAT, 32'h0000_0000, "empty entry status");
    rd(8'h3C, 32'h0000_0000, "unmapped read");
    $display("reset test done");
    frame(11'h020, 7'd2, 1'b1, 1'b0);
    wr(QRF_A_RUNWR, 32'h0000_0001);
    wr(QRF_A_CRIT_CH, 32'h0000_0003);
    wr(QRF_A_CRIT_ID, 32'h00FF_0010);
    wr(QRF_A_APPLY, 32'h0000_0000);
    rd(QRF_A_CRIT_CH, 32'h0000_0183, "channel criteria");
    poc_state <= QRF_ST_ACTIVE;
    wr(QRF_A_RUNWR, 32'h0000_0000);
    rd(QRF_A_RUNWR, 32'h0000_0001, "runtime enable");
    nq_match <= 1'b1;
    frame(11'h020, 7'd3, 1'b1, 1'b0);
    nq_match <= 1'b0;
    first_boot_slot <= 1'b1;
    nq_search_done <= 1'b0;
    frame(11'h021, 7'd1, 1'b1, 1'b0);
    first_boot_slot <= 1'b0;
    nq_search_done <= 1'b1;
    frame(11'h100, 7'd3, 1'b1, 1'b0);
    frame(11'h022, 7'd3, 1'b0, 1'b0);
    slot_payload_present <= 1'b0;
    frame(11'h023, 7'd0, 1'b1, 1'b0);
    slot_payload_present <= 1'b1;
    rd(QRF_A_STATUS, 32'h0000_0010, "status after refusals");
    $display("refusal test done");
    frame(11'h010, 7'd12, 1'b1, 1'b1);
    frame(11'h0FF, 7'd8, 1'b1, 1'b1);
    repeat (2) frame(11'(16 + {$random(seed)} % 240), 7'({$random(seed)} % 13), 1'b1, 1'b1);
    rd(QRF_A_STATUS, 32'h0000_0024, "status full");
    frame(11'h030, 7'd2, 1'b1, 1'b0);
    rd(QRF_A_STATUS, 32'h0000_0124, "status after overrun");
    pins(1'b1, 1'b1);
    wr(QRF_A_STATUS, 32'h0000_0100);
    rd(QRF_A_STATUS, 32'h0000_0024, "status lost cleared");
    pins(1'b1, 1'b0);
    drain();
    fork
      frame(11'(16 + {$random(seed)} % 240), 7'({$random(seed)} % 13), 1'b1, 1'b1);
      drain();
    join
    $display("fill and overrun test done");
    poc_state <= QRF_ST_PASSIVE;
    wr(QRF_A_CRIT_ID, 32'h0300_0300);
    frame(11'h300, 7'd1, 1'b1, 1'b0);
    wr(QRF_A_APPLY, 32'h0000_0000);
    frame(11'h300, 7'd1, 1'b1, 1'b1);
    rd(QRF_A_STATUS, 32'h0000_0024, "status after criteria change");
    $display("runtime criteria test done");
    poc_state <= QRF_ST_HALT;
    repeat (4) drain();
    wr(QRF_A_POP, 32'h0000_0000);
    rd(QRF_A_STATUS, 32'h0000_0010, "status drained");
    pins(1'b0, 1'b0);
    $display("drain test done");
    poc_state <= QRF_ST_READY;
    wr(QRF_A_CRIT_ID, 32'h0010_0010);
    rd(QRF_A_CRIT_ID, 32'h0300_0300, "criteria kept in ready");
    frame(11'h300, 7'd1, 1'b1, 1'b0);
    poc_state <= QRF_ST_ACTIVE;
    wr(QRF_A_CRIT_CH, 32'h0000_0005);
    wr(QRF_A_APPLY, 32'h0000_0000);
    rd(QRF_A_CRIT_CH, 32'h0000_0285, "channel A with null frames");
    ch_pick = 2'b01;
    frame(11'h300, 7'd1, 1'b1, 1'b0);
    ch_pick = 2'b00;
    slot_payload_present <= 1'b0;
    @(posedge ref_clk);
    frame(11'h300, 7'd2, 1'b1, 1'b1);
    slot_payload_present <= 1'b1;
    ch_pick = 2'b11;
    rd(QRF_A_STATUS, 32'h0000_0001, "status one null entry");
    drain();
    $display("channel and null test done");
    wrap_up();
  end
endmodule : tb_top

bind qrf_queue qrf_checker u_chk (.*);
